// file: rtl/rfs_pkg.sv
`default_nettype none
package rfs_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] RFS_N_OFS = 8'h0b;
  localparam logic [7:0] RFS_M_OFS = 8'h0c;
  localparam logic [7:0] RFS_N_RST = 8'h00;
  localparam logic [7:0] RFS_M_RST = 8'h00;
  // ==========================================================
  // field layout
  localparam int RFS_SRC_BIT = 7;
  localparam int RFS_M_MSB = 6;
  localparam int RFS_N_MSB = 7;
  // ==========================================================
  // frequency range, in kHz
  localparam int RFS_FMIN_KHZ = 50000;
  localparam int RFS_FMAX_KHZ = 248000;
  // recovery mode states
  typedef enum logic {RFS_NORMAL, RFS_RECOVER} rfs_state_t;
endpackage : rfs_pkg
`default_nettype wire

// file: rtl/rfs_recovery_select.sv
`timescale 1ns/10ps
`default_nettype none
module rfs_recovery_select
  import rfs_pkg::*;
#(
  parameter int REF_KHZ = 14318
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // byte register port from the serial interface
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // watchdog and ratio controls
  input wire logic wd_timeout_i,
  input wire logic recovery_release_i,
  input wire logic strap_ratio_bypass_i,
  input wire logic [4:0] latched_strap_select_i,
  input wire logic [4:0] sw_ratio_select_i,
  // synthesizer steering
  output logic recovery_active_o,
  output logic use_programmed_o,
  output logic [7:0] applied_feedback_o,
  output logic [6:0] applied_reference_o,
  output logic [4:0] applied_strap_select_o,
  output logic [4:0] ratio_select_o,
  output logic freq_update_o,
  output logic prog_in_range_o
);
  // ==========================================================
  // register state
  logic [7:0] recovery_feedback_count_r, recovery_feedback_count_nxt;
  logic [6:0] recovery_reference_count_r, recovery_reference_count_nxt;
  logic recovery_source_pick_r, recovery_source_pick_nxt;
  rfs_state_t state_r, state_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic use_prog_r, use_prog_nxt;
  logic [7:0] app_n_r, app_n_nxt;
  logic [6:0] app_m_r, app_m_nxt;
  logic [4:0] app_fs_r, app_fs_nxt;
  logic [4:0] ratio_r, ratio_nxt;
  logic upd_r, upd_nxt;
  logic range_r, range_nxt;
  logic act_r, act_nxt;
  logic wr_n, wr_m;

  // range test without a divider: min*M <= ref*N <= max*M
  function automatic logic in_range(input logic [7:0] n, input logic [6:0] m);
    logic [31:0] f;
    logic [31:0] lo;
    logic [31:0] hi;
    f = 32'(REF_KHZ) * 32'(n);
    lo = 32'(RFS_FMIN_KHZ) * 32'(m);
    hi = 32'(RFS_FMAX_KHZ) * 32'(m);
    return (m != 7'h00) && (f >= lo) && (f <= hi);
  endfunction : in_range

  assign wr_n = wr_en_i && (addr_i == RFS_N_OFS);
  assign wr_m = wr_en_i && (addr_i == RFS_M_OFS);

  // register writes and reads; unmapped reads give zero
  always_comb begin
    recovery_feedback_count_nxt = recovery_feedback_count_r;
    recovery_reference_count_nxt = recovery_reference_count_r;
    recovery_source_pick_nxt = recovery_source_pick_r;
    rdata_nxt = rdata_r;
    if (wr_n) begin
      recovery_feedback_count_nxt = wdata_i[RFS_N_MSB:0];
    end
    if (wr_m) begin
      recovery_reference_count_nxt = wdata_i[RFS_M_MSB:0];
      recovery_source_pick_nxt = wdata_i[RFS_SRC_BIT];
    end
    if (rd_en_i) begin
      case (addr_i)
        RFS_N_OFS: rdata_nxt = recovery_feedback_count_r;
        RFS_M_OFS: rdata_nxt = {recovery_source_pick_r, recovery_reference_count_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      recovery_feedback_count_r <= RFS_N_RST;
      recovery_reference_count_r <= RFS_M_RST[RFS_M_MSB:0];
      recovery_source_pick_r <= RFS_M_RST[RFS_SRC_BIT];
      rdata_r <= 8'h00;
    end else begin
      recovery_feedback_count_r <= recovery_feedback_count_nxt;
      recovery_reference_count_r <= recovery_reference_count_nxt;
      recovery_source_pick_r <= recovery_source_pick_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // recovery mode: time-out locks in, release hands back; time-out wins
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RFS_NORMAL: if (wd_timeout_i) state_nxt = RFS_RECOVER;
      RFS_RECOVER: if (recovery_release_i && !wd_timeout_i) state_nxt = RFS_NORMAL;
      default: state_nxt = RFS_NORMAL;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= RFS_NORMAL;
    end else begin
      state_r <= state_nxt;
    end
  end

  // applied frequency source; values follow the registers live, so a single
  // byte write already moves the output - the host must pair its writes
  always_comb begin
    use_prog_nxt = recovery_source_pick_nxt;
    app_n_nxt = recovery_feedback_count_nxt;
    app_m_nxt = recovery_reference_count_nxt;
    app_fs_nxt = latched_strap_select_i;
    ratio_nxt = strap_ratio_bypass_i ? sw_ratio_select_i : latched_strap_select_i;
    upd_nxt = (state_nxt == RFS_RECOVER) &&
              ((state_r == RFS_NORMAL) || wr_n || wr_m);
    range_nxt = in_range(recovery_feedback_count_nxt, recovery_reference_count_nxt);
    // own flop so the mode output is not a decode of the state word
    act_nxt = (state_nxt == RFS_RECOVER);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      use_prog_r <= 1'b0;
      app_n_r <= 8'h00;
      app_m_r <= 7'h00;
      app_fs_r <= 5'h00;
      ratio_r <= 5'h00;
      upd_r <= 1'b0;
      range_r <= 1'b0;
      act_r <= 1'b0;
    end else begin
      use_prog_r <= use_prog_nxt;
      app_n_r <= app_n_nxt;
      app_m_r <= app_m_nxt;
      app_fs_r <= app_fs_nxt;
      ratio_r <= ratio_nxt;
      upd_r <= upd_nxt;
      range_r <= range_nxt;
      act_r <= act_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign recovery_active_o = act_r;
  assign use_programmed_o = use_prog_r;
  assign applied_feedback_o = app_n_r;
  assign applied_reference_o = app_m_r;
  assign applied_strap_select_o = app_fs_r;
  assign ratio_select_o = ratio_r;
  assign freq_update_o = upd_r;
  assign prog_in_range_o = range_r;

  // ==========================================================
  // checks
  timeout_enters_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wd_timeout_i |=> recovery_active_o)
    else $error("time-out did not enter recovery");
  timeout_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !recovery_active_o && wd_timeout_i |=> freq_update_o)
    else $error("no update on recovery entry");
  write_n_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_n |=> applied_feedback_o == $past(wdata_i))
    else $error("N not applied after write");
  src_pick_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_m |=> use_programmed_o == $past(wdata_i[7]))
    else $error("source pick wrong");
  m_field_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_m |=> applied_reference_o == $past(wdata_i[6:0]))
    else $error("M field wrong");
  ratio_strap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !strap_ratio_bypass_i |=> ratio_select_o == $past(latched_strap_select_i))
    else $error("strap ratio not applied");
  ratio_sw_a: assert property (@(posedge clk_i) disable iff (rst_i)
    strap_ratio_bypass_i |=> ratio_select_o == $past(sw_ratio_select_i))
    else $error("software ratio not applied");
  write_update_a: assert property (@(posedge clk_i) disable iff (rst_i)
    recovery_active_o && !recovery_release_i && (wr_n || wr_m) |=> freq_update_o)
    else $error("write in recovery gave no update");
  range_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_m && wdata_i[6:0] == 7'h00 |=> !prog_in_range_o)
    else $error("zero M reported in range");
  // looks one edge past the reset edge, so the flops are never seen unset
  reset_val_a: assert property (@(posedge clk_i)
    rst_i |=> !use_programmed_o && applied_feedback_o == 8'h00 &&
      applied_reference_o == 7'h00 && !recovery_active_o && !freq_update_o)
    else $error("reset values not zero");
  release_exit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    recovery_active_o && recovery_release_i && !wd_timeout_i |=> !recovery_active_o)
    else $error("release did not leave recovery");
  quiet_update_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !recovery_active_o && !wd_timeout_i |=> !freq_update_o)
    else $error("update pulse outside recovery");
  read_n_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en_i && addr_i == RFS_N_OFS |=> rdata_o == $past(applied_feedback_o))
    else $error("N read back wrong");
  read_m_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en_i && addr_i == RFS_M_OFS |=> rdata_o == {$past(use_programmed_o), $past(applied_reference_o)})
    else $error("M read back wrong");
  strap_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> applied_strap_select_o == $past(latched_strap_select_i))
    else $error("strap select not followed");
  // main scenarios worth seeing at least once
  enter_prog_c: cover property (@(posedge clk_i) disable iff (rst_i)
    use_programmed_o && wd_timeout_i ##1 recovery_active_o);
  enter_strap_c: cover property (@(posedge clk_i) disable iff (rst_i)
    !use_programmed_o && wd_timeout_i ##1 recovery_active_o);
  release_c: cover property (@(posedge clk_i) disable iff (rst_i)
    recovery_active_o ##1 !recovery_active_o);
  write_recover_c: cover property (@(posedge clk_i) disable iff (rst_i)
    recovery_active_o && (wr_n || wr_m) ##1 freq_update_o);
  timeout_beats_release_c: cover property (@(posedge clk_i) disable iff (rst_i)
    recovery_active_o && recovery_release_i && wd_timeout_i ##1 recovery_active_o);
endmodule : rfs_recovery_select
`default_nettype wire

// file: bench/rfs_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// serial host stand-in: byte and word accesses on the register port
module rfs_host_model
  import rfs_pkg::*;
(
  // clock and bus side
  input wire logic clk_i,
  output logic wr_en_o = 1'b0,
  output logic rd_en_o = 1'b0,
  output logic [7:0] addr_o = 8'h00,
  output logic [7:0] wdata_o = 8'h00
);
  // one beat, held across the taking edge
  task automatic beat(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr_en_o = wr;
    rd_en_o = !wr;
    addr_o = a;
    wdata_o = d;
  endtask : beat
  // idle lines show inverted values, never a stale match
  task automatic idle();
    @(negedge clk_i);
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = ~addr_o;
    wdata_o = ~wdata_o;
  endtask : idle
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    beat(wr, a, d);
    idle();
  endtask : xfer
  // N then M on back-to-back beats, no idle between; the outputs show the new N with the old M for one cycle
  task automatic word_wr(input logic [7:0] n, input logic [7:0] m);
    beat(1'b1, RFS_N_OFS, n);
    beat(1'b1, RFS_M_OFS, m);
    idle();
  endtask : word_wr
endmodule : rfs_host_model
`default_nettype wire

// file: bench/recovery_frequency_select_bench.sv
`timescale 1ns/10ps
`default_nettype none
module recovery_frequency_select_bench;
  import rfs_pkg::*;
  // ==========================================================
  // clock, stimulus and observed outputs
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr_en, rd_en, wd_to = 1'b0, rel = 1'b0, byp = 1'b0;
  logic [7:0] addr, wdata, rdata, fb, n, m;
  logic [6:0] rf;
  logic [4:0] strap = 5'h00, sw = 5'h00, appl_strap, ratio;
  logic act, use_p, upd, in_rng;
  int seed = 32'h30df;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  rfs_host_model host_u (.clk_i(clk_i), .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr),
    .wdata_o(wdata));
  rfs_recovery_select dut_u (.clk_i(clk_i), .rst_i(rst_i), .wr_en_i(wr_en), .rd_en_i(rd_en),
    .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .wd_timeout_i(wd_to),
    .recovery_release_i(rel), .strap_ratio_bypass_i(byp), .latched_strap_select_i(strap),
    .sw_ratio_select_i(sw), .recovery_active_o(act), .use_programmed_o(use_p),
    .applied_feedback_o(fb), .applied_reference_o(rf), .applied_strap_select_o(appl_strap),
    .ratio_select_o(ratio), .freq_update_o(upd), .prog_in_range_o(in_rng));
  // cycle ceiling so a hang still reaches the verdict
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // range flag expected from the reference times N over M
  // cross-multiplied so a fraction just above the top end is not rounded in
  function automatic logic in_band(input logic [7:0] fn, input logic [6:0] fm);
    if (fm == 7'h00) return 1'b0;
    return (14318 * fn >= RFS_FMIN_KHZ * fm) && (14318 * fn <= RFS_FMAX_KHZ * fm);
  endfunction : in_band
  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    host_u.xfer(1'b1, 8'h0d, 8'hff); // unmapped write must not land
    host_u.xfer(1'b0, RFS_N_OFS, 8'h00);
    chk(rdata, RFS_N_RST);
    host_u.xfer(1'b0, RFS_M_OFS, 8'h00);
    chk(rdata, RFS_M_RST);
    chk({act, use_p}, 2'b00);
    host_u.xfer(1'b0, 8'h0d, 8'h00);
    chk(rdata, 8'h00);
    // random settings, first pass with M zero and the source pick set
    for (int i = 0; i < 24; i++) begin
      n = 8'($random(seed));
      m = (i == 0) ? 8'h80 : 8'($random(seed));
      {byp, strap, sw} = 11'($random(seed));
      host_u.word_wr(n, m);
      chk({upd, fb}, {1'b0, n});
      chk({use_p, rf}, m);
      chk(ratio, byp ? sw : strap);
      chk(appl_strap, strap);
      host_u.xfer(1'b0, RFS_N_OFS, 8'h00);
      chk(rdata, n);
      host_u.xfer(1'b0, RFS_M_OFS, 8'h00);
      chk(rdata, m);
      chk(in_rng, in_band(n, m[6:0]));
    end
    // time-out enters recovery with a single change pulse
    wd_to = 1'b1;
    @(negedge clk_i);
    wd_to = 1'b0;
    chk({act, upd, use_p}, {2'b11, m[7]});
    @(negedge clk_i);
    chk({act, upd}, 2'b10);
    // each byte alone restarts the change while recovering
    host_u.xfer(1'b1, RFS_M_OFS, 8'h85);
    chk({upd, use_p, rf}, 9'h185);
    host_u.xfer(1'b1, RFS_N_OFS, 8'h3c);
    chk({upd, fb}, 9'h13c);
    wd_to = 1'b1;
    @(negedge clk_i);
    wd_to = 1'b0;
    chk({act, upd}, 2'b10);
    rel = 1'b1;
    @(negedge clk_i);
    rel = 1'b0;
    chk(act, 1'b0);
    // strap source, written while normal: no update pulse, value reads back
    host_u.xfer(1'b1, RFS_M_OFS, 8'h05);
    chk({upd, use_p, rf}, 9'h005);
    host_u.xfer(1'b0, RFS_M_OFS, 8'h00);
    chk(rdata, 8'h05);
    host_u.xfer(1'b0, 8'h0d, 8'h00);
    chk(rdata, 8'h00);
    // time-out beats a release that lands in the same cycle
    wd_to = 1'b1;
    @(negedge clk_i);
    chk({act, upd, use_p}, 3'b110);
    rel = 1'b1;
    @(negedge clk_i);
    wd_to = 1'b0;
    rel = 1'b0;
    chk({act, upd}, 2'b10);
    rel = 1'b1;
    @(negedge clk_i);
    rel = 1'b0;
    chk(act, 1'b0);
    tally_and_finish();
  end
endmodule : recovery_frequency_select_bench
`default_nettype wire
